// ### startup_sequencer.sv
// Start-up sequencer: enable wait, settling, trip-level sample, soft-start ramp, hiccup
`include "startup_sequencer_defines.svh"
`timescale 1ns/1ps
module startup_sequencer #(
  parameter int RAMP_STEP_CYCLES   = `RAMP_STEP_CYCLES,
  parameter int SAMPLE_STEP_CYCLES = `SAMPLE_STEP_CYCLES
) (
  input  wire logic                CLOCK,
  input  wire logic                SRST,
  input  wire logic                CE,
  input  wire logic                BIAS_SUPPLY_GOOD,
  input  wire logic                ENABLE_ABOVE_THRESHOLD,
  input  wire logic                TRIP_DAC_REACHED,
  input  wire logic                RAMP_ABOVE_OUTPUT,
  input  wire logic                OVERCURRENT_TRIP,
  output logic                     SWITCH_ENABLE,
  output logic                     LOW_SIDE_GATE_ENABLE,
  output logic                     TRIP_SOURCE_ENABLE,
  output logic [`DAC_W-1:0]        TRIP_LEVEL,
  output logic [`RAMP_W-1:0]       SOFT_START_REF,
  output logic                     ERROR_AMP_ENABLE,
  output logic                     SOFT_START_DONE,
  output logic                     HICCUP_ACTIVE
);

  // ----------------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------------
  logic [4:0] pins_s;
  logic       bias_good;
  logic       en_above;
  logic       dac_reached;
  logic       ramp_above;
  logic       overcurrent;

  level_sync #(
    .W (5)
  ) u_sync (
    .clk  (CLOCK),
    .srst (SRST),
    .ce   (CE),
    .d    ({BIAS_SUPPLY_GOOD, ENABLE_ABOVE_THRESHOLD, TRIP_DAC_REACHED,
            RAMP_ABOVE_OUTPUT, OVERCURRENT_TRIP}),
    .q    (pins_s)
  );

  assign bias_good   = pins_s[4];
  assign en_above    = pins_s[3];
  assign dac_reached = pins_s[2];
  assign ramp_above  = pins_s[1];
  assign overcurrent = pins_s[0];

  // ----------------------------------------------------------------------------
  // Step timers
  // ----------------------------------------------------------------------------
  startup_sequencer_pkg::seq_s s_q;
  startup_sequencer_pkg::seq_s s_d;
  logic                        timer_clear;
  logic                        ramp_tick;
  logic                        sample_tick;

  // Restart both prescalers on every state change so each phase starts whole
  assign timer_clear = (s_d.state != s_q.state);

  // One ramp step is 1/64 of 6.8ms; the settling delay reuses it 64 times
  step_timer #(
    .PERIOD (RAMP_STEP_CYCLES)
  ) u_ramp_timer (
    .clk   (CLOCK),
    .srst  (SRST),
    .ce    (CE),
    .clear (timer_clear),
    .tick  (ramp_tick)
  );

  step_timer #(
    .PERIOD (SAMPLE_STEP_CYCLES)
  ) u_sample_timer (
    .clk   (CLOCK),
    .srst  (SRST),
    .ce    (CE),
    .clear (timer_clear),
    .tick  (sample_tick)
  );

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic ramp_full(input logic [6:0] r);
    ramp_full = (r == 7'(`RAMP_STEPS));
  endfunction

  function automatic logic after_enable(input startup_sequencer_pkg::seq_state_e st);
    after_enable = (st != startup_sequencer_pkg::ST_IDLE) && (st != startup_sequencer_pkg::ST_WAIT_EN);
  endfunction

  function automatic logic switching_phase(input startup_sequencer_pkg::seq_state_e st);
    switching_phase = (st == startup_sequencer_pkg::ST_RAMP) || (st == startup_sequencer_pkg::ST_RUN);
  endfunction

  // ----------------------------------------------------------------------------
  // Sample end
  // ----------------------------------------------------------------------------
  logic sample_end;

  // A zero setting ends at once; the top code bounds the phase at its 3.4ms maximum
  assign sample_end = dac_reached || (s_q.dac == `DAC_MAX);

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Each phase states its own flags, except that ST_INIT and ST_RAMP keep hiccup, ST_RAMP keeps a set sw_en and ST_WAIT_EN keeps trip_src
    case (s_q.state)
      startup_sequencer_pkg::ST_IDLE: begin
        s_d.sw_en    = 1'b0;
        s_d.trip_src = 1'b0;
        s_d.err_amp  = 1'b0;
        s_d.ss_done  = 1'b0;
        s_d.hiccup   = 1'b0;
        s_d.ramp     = 7'h00;
        s_d.steps    = 7'h00;
        if (bias_good) begin
          s_d.state = startup_sequencer_pkg::ST_WAIT_EN;
        end
      end
      startup_sequencer_pkg::ST_WAIT_EN: begin
        s_d.sw_en   = 1'b0;
        s_d.err_amp = 1'b0;
        s_d.ss_done = 1'b0;
        s_d.ramp    = 7'h00;
        s_d.hiccup  = 1'b0;
        // Timing starts at the threshold crossing, not at release
        if (en_above) begin
          s_d.state    = startup_sequencer_pkg::ST_SETTLE;
          s_d.steps    = 7'h00;
          // The trip comparator lags the DAC, so the old level is dropped long before sampling
          s_d.dac      = 6'h00;
          s_d.trip_src = 1'b1;
        end
      end
      startup_sequencer_pkg::ST_SETTLE: begin
        s_d.trip_src = 1'b1;
        s_d.sw_en    = 1'b0;
        s_d.err_amp  = 1'b0;
        s_d.ss_done  = 1'b0;
        s_d.hiccup   = 1'b0;
        s_d.ramp     = 7'h00;
        if (ramp_tick) begin
          s_d.steps = s_q.steps + 7'h01;
          if (s_q.steps == 7'(`RAMP_STEPS - 1)) begin
            s_d.state = startup_sequencer_pkg::ST_SAMPLE;
            s_d.dac   = 6'h00;
          end
        end
      end
      startup_sequencer_pkg::ST_SAMPLE: begin
        s_d.trip_src = 1'b1;
        s_d.sw_en    = 1'b0;
        s_d.err_amp  = 1'b0;
        s_d.ss_done  = 1'b0;
        s_d.hiccup   = 1'b0;
        s_d.ramp     = 7'h00;
        if (sample_end) begin
          s_d.state    = startup_sequencer_pkg::ST_INIT;
          s_d.trip_src = 1'b0;
          s_d.steps    = 7'h00;
        end else if (sample_tick) begin
          s_d.dac = s_q.dac + 6'h01;
        end
      end
      startup_sequencer_pkg::ST_INIT: begin
        s_d.sw_en = 1'b0;
        s_d.ramp  = 7'h00;
        s_d.trip_src = 1'b0;
        s_d.err_amp  = 1'b0;
        s_d.ss_done  = 1'b0;
        if (ramp_tick) begin
          s_d.steps = s_q.steps + 7'h01;
          if (s_q.steps == `INIT_STEPS - 7'h01) begin
            s_d.state   = startup_sequencer_pkg::ST_RAMP;
            s_d.err_amp = 1'b1;
            s_d.hiccup  = 1'b0;
          end
        end
      end
      startup_sequencer_pkg::ST_RAMP: begin
        s_d.trip_src = 1'b0;
        s_d.err_amp  = 1'b1;
        s_d.ss_done  = 1'b0;
        // Switching waits for the ramp to pass a pre-biased output
        if (ramp_above) begin
          s_d.sw_en = 1'b1;
        end
        if (ramp_tick) begin
          s_d.ramp = s_q.ramp + 7'h01;
          if (s_q.ramp == 7'(`RAMP_STEPS - 1)) begin
            s_d.state   = startup_sequencer_pkg::ST_RUN;
            s_d.ss_done = 1'b1;
            s_d.sw_en   = 1'b1;
          end
        end
      end
      startup_sequencer_pkg::ST_RUN: begin
        s_d.ramp  = 7'(`RAMP_STEPS);
        s_d.sw_en = 1'b1;
        s_d.trip_src = 1'b0;
        s_d.err_amp  = 1'b1;
        s_d.ss_done  = 1'b1;
        s_d.hiccup   = 1'b0;
      end
      startup_sequencer_pkg::ST_HICCUP: begin
        // Dummy timeouts keep the held trip level; no new sample is taken
        s_d.sw_en   = 1'b0;
        s_d.err_amp = 1'b0;
        s_d.trip_src = 1'b0;
        s_d.ss_done  = 1'b0;
        s_d.hiccup   = 1'b1;
        if (ramp_tick) begin
          if (ramp_full(s_q.ramp)) begin
            s_d.ramp    = 7'h00;
            s_d.dummies = s_q.dummies + 2'h1;
            if (s_q.dummies == `DUMMY_CYCLES - 2'h1) begin
              s_d.state = startup_sequencer_pkg::ST_INIT;
              s_d.steps = 7'h00;
            end
          end else begin
            s_d.ramp = s_q.ramp + 7'h01;
          end
        end
      end
      default: begin
        s_d.state = startup_sequencer_pkg::ST_IDLE;
      end
    endcase

    // Overcurrent only matters once switching may be on
    if (overcurrent && switching_phase(s_q.state)) begin
      s_d.state   = startup_sequencer_pkg::ST_HICCUP;
      s_d.sw_en   = 1'b0;
      s_d.err_amp = 1'b0;
      s_d.ss_done = 1'b0;
      s_d.hiccup  = 1'b1;
      s_d.ramp    = 7'h00;
      s_d.dummies = 2'h0;
    end

    // Enable pulled low: full restart, fresh sample follows release
    if (!en_above && after_enable(s_q.state)) begin
      s_d.state    = startup_sequencer_pkg::ST_WAIT_EN;
      s_d.sw_en    = 1'b0;
      s_d.trip_src = 1'b0;
      s_d.err_amp  = 1'b0;
      s_d.ss_done  = 1'b0;
      s_d.hiccup   = 1'b0;
      s_d.ramp     = 7'h00;
    end

    // Bias loss has top priority and drops the held level
    if (!bias_good) begin
      s_d.state    = startup_sequencer_pkg::ST_IDLE;
      s_d.dac      = 6'h00;
      s_d.sw_en    = 1'b0;
      s_d.trip_src = 1'b0;
      s_d.err_amp  = 1'b0;
      s_d.ss_done  = 1'b0;
      s_d.hiccup   = 1'b0;
      s_d.ramp     = 7'h00;
      s_d.steps    = 7'h00;
      s_d.dummies  = 2'h0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      s_q.state   <= startup_sequencer_pkg::ST_IDLE;
      s_q.ramp    <= 7'h00;
      s_q.dac     <= 6'h00;
      s_q.steps   <= 7'h00;
      s_q.dummies <= 2'h0;
      s_q.sw_en   <= 1'b0;
      s_q.trip_src <= 1'b0;
      s_q.err_amp <= 1'b0;
      s_q.ss_done <= 1'b0;
      s_q.hiccup  <= 1'b0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign SWITCH_ENABLE        = s_q.sw_en;
  assign LOW_SIDE_GATE_ENABLE = s_q.sw_en & ~s_q.trip_src;
  assign TRIP_SOURCE_ENABLE   = s_q.trip_src;
  assign TRIP_LEVEL           = s_q.dac;
  assign SOFT_START_REF       = s_q.ramp;
  assign ERROR_AMP_ENABLE     = s_q.err_amp;
  assign SOFT_START_DONE      = s_q.ss_done;
  assign HICCUP_ACTIVE        = s_q.hiccup;

endmodule

// ### startup_sequencer_defines.svh
// Timing and width constants for the start-up sequencer
//
// Overview of operation
// - A rising bias-supply power-good starts the trip-level sample-and-hold before any soft-start work.
// - While the enable node is held low, the whole start-up sequence waits until it is released and above threshold.
// - The sequencing timer starts only when the enable node crosses its disable threshold.
// - After the threshold crossing a nominal 6.8ms settling delay runs before trip-level sampling.
// - During settling the low-side driver is off and the trip-setting current source feeds the trip-setting pin.
// - Trip-level sampling lasts from zero up to a nominal 3.4ms, longer for higher trip settings.
// - The sampled trip level is held in a counter driving a DAC without decay while the bias supply stays good.
// - When sampling completes, soft-start begins with a short initialization interval before the ramp.
// - Soft-start ramps the reference from zero to the final 0.6V level over a nominal 6.8ms.
// - The ramp is digital, 64 equal steps, with no external rate adjustment.
// - After the initialization interval the error amplifier is enabled for the rest of soft-start.
// - Soft-start is complete when the ramp value reaches the final level, and the reference then holds there.
// - With the output pre-biased low, both switches stay off until the ramp exceeds the output, then ramping continues.
// - With the output pre-biased high, both switches stay off until soft-start ends, then the output is regulated down.
// - An enable pulled low after soft-start and released reruns the full start-up including a fresh trip sample.
// - An overcurrent shuts the output off and runs hiccup cycles of two dummy soft-starts then one real one, forever.
`ifndef STARTUP_SEQUENCER_DEFINES_SVH
`define STARTUP_SEQUENCER_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------------
`define CLK_MHZ            50
`define SETTLE_TIME_US     6800
`define SS_TIME_US         6800
`define SAMPLE_MAX_TIME_US 3400

// ----------------------------------------------------------------------------
// Widths and step counts
// ----------------------------------------------------------------------------
`define RAMP_STEPS         64
`define RAMP_W             7
`define DAC_W              6
`define DAC_MAX            6'h3F
`define INIT_STEPS         7'h02
`define DUMMY_CYCLES       2'h2

// Cycles per ramp step and per DAC step, rounded down
`define RAMP_STEP_CYCLES   ((`SS_TIME_US * `CLK_MHZ) / `RAMP_STEPS)
`define SAMPLE_STEP_CYCLES ((`SAMPLE_MAX_TIME_US * `CLK_MHZ) / `RAMP_STEPS)

`endif

// ### startup_sequencer_pkg.sv
// Types of the start-up sequencer
package startup_sequencer_pkg;

  // ----------------------------------------------------------------------------
  // Sequence states
  // ----------------------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_WAIT_EN = 8'h02,
    ST_SETTLE  = 8'h04,
    ST_SAMPLE  = 8'h08,
    ST_INIT    = 8'h10,
    ST_RAMP    = 8'h20,
    ST_RUN     = 8'h40,
    ST_HICCUP  = 8'h80
  } seq_state_e;

  // ----------------------------------------------------------------------------
  // Whole state of the sequencer
  // ----------------------------------------------------------------------------
  typedef struct packed {
    seq_state_e  state;
    logic [6:0]  ramp;
    logic [5:0]  dac;
    logic [6:0]  steps;
    logic [1:0]  dummies;
    logic        sw_en;
    logic        trip_src;
    logic        err_amp;
    logic        ss_done;
    logic        hiccup;
  } seq_s;

endpackage

// ### level_sync.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ### step_timer.sv
// Prescaler giving a one-cycle tick every PERIOD enabled cycles
`timescale 1ns/1ps
module step_timer #(
  parameter int PERIOD = 16
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic clear,
  output logic      tick
);

  logic [19:0] count_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= 20'h00000;
      tick    <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        count_q <= 20'h00000;
        tick    <= 1'b0;
      end else if (count_q == 20'(PERIOD - 1)) begin
        count_q <= 20'h00000;
        tick    <= 1'b1;
      end else begin
        count_q <= count_q + 20'h00001;
        tick    <= 1'b0;
      end
    end
  end

endmodule

// ### startup_sequencer_sva.sv
// Assertion checker for the start-up sequencer
`include "startup_sequencer_defines.svh"
`timescale 1ns/1ps
module startup_sequencer_chk #(
  parameter int RAMP_STEP_CYCLES   = 8,
  parameter int SAMPLE_STEP_CYCLES = 4
) (
  input wire logic               CLOCK,
  input wire logic               SRST,
  input wire logic               CE,
  input wire logic               BIAS_SUPPLY_GOOD,
  input wire logic               ENABLE_ABOVE_THRESHOLD,
  input wire logic               TRIP_DAC_REACHED,
  input wire logic               RAMP_ABOVE_OUTPUT,
  input wire logic               OVERCURRENT_TRIP,
  input wire logic               SWITCH_ENABLE,
  input wire logic               LOW_SIDE_GATE_ENABLE,
  input wire logic               TRIP_SOURCE_ENABLE,
  input wire logic [`DAC_W-1:0]  TRIP_LEVEL,
  input wire logic [`RAMP_W-1:0] SOFT_START_REF,
  input wire logic               ERROR_AMP_ENABLE,
  input wire logic               SOFT_START_DONE,
  input wire logic               HICCUP_ACTIVE
);
  // --------------------------------
  // Properties
  // --------------------------------
  // Pin levels pass two sync flops, so the four-cycle windows below cover the latency
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  a_no_early_ramp: assert property (TRIP_SOURCE_ENABLE |-> SOFT_START_REF == 7'h00 && !SOFT_START_DONE)
    else $error("ramp active before trip sampling ended");
  a_low_side_off: assert property (TRIP_SOURCE_ENABLE |-> !LOW_SIDE_GATE_ENABLE && !SWITCH_ENABLE)
    else $error("switching while trip source on");
  a_ref_one_step: assert property ($changed(SOFT_START_REF) |-> SOFT_START_REF == $past(SOFT_START_REF) + 7'h01 || SOFT_START_REF == 7'h00)
    else $error("reference moved by more than one step");
  a_done_full: assert property (SOFT_START_DONE |-> SOFT_START_REF == 7'h40 && SWITCH_ENABLE && ERROR_AMP_ENABLE)
    else $error("done without full reference and switching");
  a_init_gap: assert property ($fell(TRIP_SOURCE_ENABLE) |-> !ERROR_AMP_ENABLE [*2])
    else $error("amplifier enabled without init interval");
  a_amp_after_init: assert property ($rose(ERROR_AMP_ENABLE) |-> !TRIP_SOURCE_ENABLE && !$past(TRIP_SOURCE_ENABLE, 2))
    else $error("amplifier enabled straight after sampling");
  a_prebias_wait: assert property ($rose(SWITCH_ENABLE) && !SOFT_START_DONE |-> $past(RAMP_ABOVE_OUTPUT, 3))
    else $error("switching before ramp passed output");
  a_bias_loss: assert property ((!BIAS_SUPPLY_GOOD && CE) [*4] |-> TRIP_LEVEL == 6'h00 && !SWITCH_ENABLE && !TRIP_SOURCE_ENABLE)
    else $error("state kept after bias loss");
  a_enable_low: assert property ((!ENABLE_ABOVE_THRESHOLD && CE) [*4] |-> !SWITCH_ENABLE && !ERROR_AMP_ENABLE && !TRIP_SOURCE_ENABLE)
    else $error("sequence runs with enable low");
  a_overcurrent_off: assert property (SOFT_START_DONE ##0 (OVERCURRENT_TRIP && CE && BIAS_SUPPLY_GOOD && ENABLE_ABOVE_THRESHOLD) [*4] |-> !SWITCH_ENABLE && HICCUP_ACTIVE)
    else $error("overcurrent did not shut output off");
  a_hiccup_keeps: assert property (HICCUP_ACTIVE && $past(HICCUP_ACTIVE) |-> !TRIP_SOURCE_ENABLE && $stable(TRIP_LEVEL))
    else $error("trip level resampled during hiccup");

  c_done: cover property ($rose(SOFT_START_DONE));
  c_hiccup: cover property ($rose(HICCUP_ACTIVE));
  c_prebias: cover property ($rose(SWITCH_ENABLE) && !SOFT_START_DONE);
endmodule

bind startup_sequencer startup_sequencer_chk #(
  .RAMP_STEP_CYCLES(RAMP_STEP_CYCLES), .SAMPLE_STEP_CYCLES(SAMPLE_STEP_CYCLES)
) u_startup_sequencer_chk (
  .CLOCK(CLOCK), .SRST(SRST), .CE(CE), .BIAS_SUPPLY_GOOD(BIAS_SUPPLY_GOOD),
  .ENABLE_ABOVE_THRESHOLD(ENABLE_ABOVE_THRESHOLD), .TRIP_DAC_REACHED(TRIP_DAC_REACHED),
  .RAMP_ABOVE_OUTPUT(RAMP_ABOVE_OUTPUT), .OVERCURRENT_TRIP(OVERCURRENT_TRIP), .SWITCH_ENABLE(SWITCH_ENABLE),
  .LOW_SIDE_GATE_ENABLE(LOW_SIDE_GATE_ENABLE), .TRIP_SOURCE_ENABLE(TRIP_SOURCE_ENABLE),
  .TRIP_LEVEL(TRIP_LEVEL), .SOFT_START_REF(SOFT_START_REF), .ERROR_AMP_ENABLE(ERROR_AMP_ENABLE),
  .SOFT_START_DONE(SOFT_START_DONE), .HICCUP_ACTIVE(HICCUP_ACTIVE)
);

// ### enable_pulldown_model.sv
// Model of the external open-drain disable device on the enable node
`timescale 1ns/1ps
module enable_pulldown_model #(
  parameter int CHARGE_CYCLES = 6
) (
  input  wire logic clk,
  input  wire logic hold_low,
  output logic      node_above
);
  int charge_q = 0;

  // Released node charges slowly, so the threshold crossing lags the release
  always @(posedge clk) begin
    if (hold_low) begin
      charge_q <= 0;
      node_above <= 1'b0;
    end else if (charge_q < CHARGE_CYCLES) begin
      charge_q <= charge_q + 1;
      node_above <= 1'b0;
    end else begin
      node_above <= 1'b1;
    end
  end
endmodule

// ### test_startup_sequencer.sv
// Self-checking bench for the start-up sequencer
`timescale 1ns/1ps
module test_startup_sequencer;
  // --------------------------------
  // Stimulus and observation
  // --------------------------------
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       ce = 1'b1;
  logic       bias = 1'b0;
  logic       hold_low = 1'b0;
  logic       oc_short = 1'b0;
  logic       trip_reach = 1'b0;
  logic       ramp_above = 1'b0;
  logic [6:0] thr = 7'h00;
  logic [6:0] pre = 7'h00;
  logic       en_above, sw_en, ls_en, trip_src, amp_en, done, hic;
  logic [5:0] trip_lvl;
  logic [6:0] ref_q;
  int         err_total = 0;
  int         n_tests = 0;
  int         cyc;
  int         tot;
  typedef struct {logic [6:0] thr; logic [6:0] pre; logic [6:0] trip; logic [6:0] sw_ref;} row_s;
  row_s       rows [4] = '{'{7'h00, 7'h00, 7'h00, 7'h01}, '{7'h05, 7'h14, 7'h05, 7'h15},
                           '{7'h28, 7'h3F, 7'h28, 7'h40}, '{7'h40, 7'h41, 7'h3F, 7'h40}};

  always #10 clock = ~clock;

  startup_sequencer #(.RAMP_STEP_CYCLES(8), .SAMPLE_STEP_CYCLES(4)) u_startup_sequencer (
    .CLOCK(clock), .SRST(srst), .CE(ce), .BIAS_SUPPLY_GOOD(bias), .ENABLE_ABOVE_THRESHOLD(en_above),
    .TRIP_DAC_REACHED(trip_reach), .RAMP_ABOVE_OUTPUT(ramp_above), .OVERCURRENT_TRIP(oc_short),
    .SWITCH_ENABLE(sw_en), .LOW_SIDE_GATE_ENABLE(ls_en), .TRIP_SOURCE_ENABLE(trip_src),
    .TRIP_LEVEL(trip_lvl), .SOFT_START_REF(ref_q), .ERROR_AMP_ENABLE(amp_en),
    .SOFT_START_DONE(done), .HICCUP_ACTIVE(hic)
  );
  enable_pulldown_model u_enable_pulldown_model (.clk(clock), .hold_low(hold_low), .node_above(en_above));

  // Trip pin and output comparators; a threshold of 64 is never met, forcing the full sample
  always @(posedge clock) begin
    trip_reach <= {1'b0, trip_lvl} >= thr;
    ramp_above <= ref_q > pre;
  end

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Bounded wait on one output; the cycle count lands in cyc
  task automatic wait_for(input int sel, input logic val, input int bound);
    logic s;
    cyc = 0;
    do begin
      @(posedge clock);
      #1;
      case (sel)
        0: s = done;
        1: s = trip_src;
        2: s = hic;
        3: s = sw_en;
        default: s = amp_en;
      endcase
      cyc++;
    end while (s !== val && cyc < bound);
    if (s !== val) begin
      err_total++;
      $display("unexpected at %0t: wait %0d seen %h expected %h", $time, sel, s, val);
      finish_test();
    end
  endtask

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check(8'({sw_en, ls_en, amp_en, done, hic, trip_src}), 8'h00);
    check(8'(trip_lvl), 8'h00);
    check(8'(ref_q), 8'h00);
    foreach (rows[i]) begin
      @(posedge clock);
      bias <= 1'b0;
      thr <= rows[i].thr;
      pre <= rows[i].pre;
      repeat (6) @(posedge clock);
      #1;
      check(8'(trip_lvl), 8'h00);
      @(posedge clock);
      bias <= 1'b1;
      wait_for(1, 1'b1, 60);
      check(8'({ls_en, sw_en}), 8'h00);
      wait_for(1, 1'b0, 900);
      check(8'(cyc >= 512 + 4 * rows[i].trip && cyc <= 528 + 4 * rows[i].trip), 8'h01);
      check(8'(trip_lvl), 8'(rows[i].trip));
      wait_for(4, 1'b1, 40);
      check(8'(cyc >= 16 && cyc <= 20), 8'h01);
      wait_for(3, 1'b1, 600);
      tot = cyc;
      check(8'(ref_q), 8'(rows[i].sw_ref));
      wait_for(0, 1'b1, 600);
      check(8'(tot + cyc >= 504 && tot + cyc <= 524), 8'h01);
      repeat (20) @(posedge clock);
      #1;
      check(8'(ref_q), 8'h40);
      check(8'({ls_en, sw_en, amp_en}), 8'h07);
    end
    // Short that persists through one retry, then clears
    @(posedge clock);
    oc_short <= 1'b1;
    wait_for(2, 1'b1, 10);
    check(8'({sw_en, amp_en, done}), 8'h00);
    wait_for(2, 1'b0, 1200);
    check(8'(cyc >= 1040 && cyc <= 1075), 8'h01);
    check(8'(trip_lvl), 8'h3F);
    wait_for(2, 1'b1, 10);
    @(posedge clock);
    oc_short <= 1'b0;
    wait_for(0, 1'b1, 2000);
    // Disable after soft-start, release, freeze the clock enable just after settling starts
    @(posedge clock);
    thr <= 7'h0A;
    hold_low <= 1'b1;
    repeat (10) @(posedge clock);
    #1;
    check(8'({sw_en, amp_en, done}), 8'h00);
    @(posedge clock);
    hold_low <= 1'b0;
    wait_for(1, 1'b1, 40);
    check(8'(cyc >= 6), 8'h01);
    @(posedge clock);
    ce <= 1'b0;
    repeat (600) @(posedge clock);
    ce <= 1'b1;
    #1;
    check(8'(trip_src), 8'h01);
    wait_for(1, 1'b0, 900);
    check(8'(trip_lvl), 8'h0A);
    wait_for(0, 1'b1, 700);
    // Enable held low through power-up
    @(posedge clock);
    bias <= 1'b0;
    hold_low <= 1'b1;
    repeat (6) @(posedge clock);
    bias <= 1'b1;
    repeat (700) @(posedge clock);
    #1;
    check(8'({trip_src, amp_en, done}), 8'h00);
    @(posedge clock);
    hold_low <= 1'b0;
    wait_for(1, 1'b1, 40);
    wait_for(0, 1'b1, 2000);
    // Reset in mid-run clears everything, then the sequence starts over
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check(8'({sw_en, ls_en, amp_en, done, hic, trip_src}), 8'h00);
    check(8'(trip_lvl), 8'h00);
    check(8'(ref_q), 8'h00);
    @(posedge clock);
    srst <= 1'b0;
    wait_for(1, 1'b1, 40);
    finish_test();
  end
endmodule
